// ===== shared/eep_consts.svh
/*
  Constants of the three-wire EEPROM command engine: opcodes, sizes,
  fill values and timing figures.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

`define EEP_OPC_READ 2'h2
`define EEP_OPC_WRITE 2'h1
`define EEP_OPC_ERASE 2'h3
`define EEP_OPC_EXT 2'h0
`define EEP_EXT_ERASE_WHOLE_ARRAY 2'h2
`define EEP_EXT_WRITE_WHOLE_ARRAY 2'h1
`define EEP_EXT_EN 2'h3
`define EEP_EXT_DIS 2'h0
`define EEP_BYTES 512
`define EEP_ERASED 8'hFF
`define EEP_ALAST_X8 5'h08
`define EEP_ALAST_X16 5'h07
`define EEP_DLAST_X8 5'h07
`define EEP_DLAST_X16 5'h0F
`define EEP_ORG_PIN 2'h0
`define EEP_ORG_X8 2'h1
`define EEP_ORG_X16 2'h2
`define EEP_CLK_NS 4
`define EEP_CSL_NS 250
`define EEP_PROG_NS 6000000

`endif

// ===== shared/eep_pkg.sv
/*
  Types of the three-wire EEPROM command engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package eep_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADR, ST_DAT, ST_RD, ST_DONE
  } eep_lst_t;

  typedef enum logic [2:0] {
    K_READ, K_WRITE, K_ERASE, K_ERASE_WHOLE_ARRAY, K_WRITE_WHOLE_ARRAY, K_EN, K_DIS
  } eep_kind_t;

endpackage

// ===== hdl/eep_cmd_engine.sv
/*
  Instruction engine of a 4 Kbit three-wire serial EEPROM: serial
  decode on the host clock, self-timed programming on the core clock.
  Assumes sclk only toggles while chip_sel is high, and chip_sel stays
  high at least 16 ns after the last clock edge of an instruction.
*/
`timescale 1ns/1ns
`include "eep_consts.svh"

// How it works
// - Erase sets addressed word to all ones
// - Erase starts at select fall, or early
// - Status shown after select low long enough
// - Start bit then select low hides status
// - Erase-all sets whole array to ones
// - Programming finishes without serial clocks
// - Power up disabled; enable and disable commands
// - Reads ignore the programming enable state
// - Read gives dummy zero then word
// - Held select keeps reading next words
// - Write takes word, then self-timed cycle
// - Write-all fills array, only when enabled
// - Select low waits for running cycle
// - Select low resets serial control logic
// - Bits captured on rising serial clock
// - No start bit, clocks change nothing
// - Exact bit count, then ignore rest
// - Status stays off if select held low
// - Size pin high x16, low x8
// - Output changes after rising clock edge
// - Start is first high input with select
// - Two-bit opcodes plus extended codes
// - Address and data lengths per size
// - Output floats unless data or status
module eep_cmd_engine #(
  parameter int PROG_CYC = `EEP_PROG_NS / `EEP_CLK_NS,
  parameter bit HV_START = 1'b0,
  parameter logic [1:0] ORG_MODE = `EEP_ORG_PIN
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic chip_sel,
  input wire logic serial_in,
  input wire logic word_size_select,
  output logic serial_out,
  output logic serial_out_oe,
  output logic prog_busy,
  output logic prog_enabled
);

  localparam logic [6:0] CSL_CYC =
    7'((`EEP_CSL_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS);
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYC - 1);

  logic [7:0] mem [0:`EEP_BYTES-1];

  function automatic logic [15:0] rd_word(
    input logic [8:0] a,
    input logic x16
  );
    logic [15:0] w;
    w = {mem[a], 8'h00};
    if (x16)
    begin
      w = {mem[{a[7:0], 1'b1}], mem[{a[7:0], 1'b0}]};
    end
    return w;
  endfunction

  function automatic eep_pkg::eep_kind_t dec_kind(
    input logic [1:0] op,
    input logic [8:0] a,
    input logic x16
  );
    logic [1:0] top;
    eep_pkg::eep_kind_t k;
    top = x16 ? a[7:6] : a[8:7];
    k = eep_pkg::K_DIS;
    case (op)
      `EEP_OPC_READ: k = eep_pkg::K_READ;
      `EEP_OPC_WRITE: k = eep_pkg::K_WRITE;
      `EEP_OPC_ERASE: k = eep_pkg::K_ERASE;
      default:
        case (top)
          `EEP_EXT_ERASE_WHOLE_ARRAY: k = eep_pkg::K_ERASE_WHOLE_ARRAY;
          `EEP_EXT_WRITE_WHOLE_ARRAY: k = eep_pkg::K_WRITE_WHOLE_ARRAY;
          `EEP_EXT_EN: k = eep_pkg::K_EN;
          default: k = eep_pkg::K_DIS;
        endcase
    endcase
    return k;
  endfunction

  // Serial side, held in reset while deselected, except the size pin synchroniser
  wire lrst_n = chip_sel & rst_n;

  logic org_s1_ff, org_s2_ff;
  eep_pkg::eep_lst_t st_ff;
  logic [4:0] cnt_ff;
  logic [1:0] opc_ff;
  logic [8:0] adr_ff, radr_ff;
  logic [15:0] dat_ff, sr_ff;
  logic x16_ff, done_ff, start_ff, rd_on_ff, rd_bit_ff;

  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      org_s1_ff <= 1'b0;
      org_s2_ff <= 1'b0;
    end
    else
    begin
      org_s1_ff <= word_size_select;
      org_s2_ff <= org_s1_ff;
    end
  end

  wire x16 = (ORG_MODE == `EEP_ORG_X16) ? 1'b1 :
    (ORG_MODE == `EEP_ORG_X8) ? 1'b0 : org_s2_ff;
  wire [4:0] alast = x16 ? `EEP_ALAST_X16 : `EEP_ALAST_X8;
  wire [4:0] dlast = x16 ? `EEP_DLAST_X16 : `EEP_DLAST_X8;
  wire [8:0] nadr = {adr_ff[7:0], serial_in};
  wire [1:0] ntop = x16 ? nadr[7:6] : nadr[8:7];
  wire adr_end = (st_ff == eep_pkg::ST_ADR) && (cnt_ff == alast);
  wire has_dat = (opc_ff == `EEP_OPC_WRITE) ||
    ((opc_ff == `EEP_OPC_EXT) && (ntop == `EEP_EXT_WRITE_WHOLE_ARRAY));

  // Sequencer; bits taken on rising edge only
  always_ff @(posedge sclk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      st_ff <= eep_pkg::ST_IDLE;
      cnt_ff <= 5'h00;
    end
    else
    begin
      case (st_ff)
        eep_pkg::ST_IDLE:
          if (serial_in)
          begin
            st_ff <= eep_pkg::ST_OPC;
            cnt_ff <= 5'h00;
          end
        eep_pkg::ST_OPC:
          if (cnt_ff == 5'h01)
          begin
            st_ff <= eep_pkg::ST_ADR;
            cnt_ff <= 5'h00;
          end
          else
          begin
            cnt_ff <= cnt_ff + 5'h01;
          end
        eep_pkg::ST_ADR:
          if (adr_end)
          begin
            cnt_ff <= 5'h00;
            if (opc_ff == `EEP_OPC_READ)
            begin
              st_ff <= eep_pkg::ST_RD;
            end
            else if (has_dat)
            begin
              st_ff <= eep_pkg::ST_DAT;
            end
            else
            begin
              st_ff <= eep_pkg::ST_DONE;
            end
          end
          else
          begin
            cnt_ff <= cnt_ff + 5'h01;
          end
        eep_pkg::ST_DAT:
          if (cnt_ff == dlast)
          begin
            st_ff <= eep_pkg::ST_DONE;
          end
          else
          begin
            cnt_ff <= cnt_ff + 5'h01;
          end
        eep_pkg::ST_RD:
          cnt_ff <= (cnt_ff == dlast) ? 5'h00 : cnt_ff + 5'h01;
        default:
          st_ff <= eep_pkg::ST_DONE;
      endcase
    end
  end

  always_ff @(posedge sclk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      opc_ff <= 2'h0;
      adr_ff <= 9'h000;
      dat_ff <= 16'h0000;
      x16_ff <= 1'b0;
    end
    else if (st_ff == eep_pkg::ST_OPC)
    begin
      opc_ff <= {opc_ff[0], serial_in};
      x16_ff <= x16;
    end
    else if (st_ff == eep_pkg::ST_ADR)
    begin
      adr_ff <= nadr;
    end
    else if (st_ff == eep_pkg::ST_DAT)
    begin
      dat_ff <= {dat_ff[14:0], serial_in};
    end
  end

  // Words stay frozen while done is up, so the core may sample them
  always_ff @(posedge sclk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      done_ff <= 1'b0;
      start_ff <= 1'b0;
    end
    else
    begin
      if (st_ff == eep_pkg::ST_IDLE && serial_in)
      begin
        start_ff <= 1'b1;
      end
      if ((adr_end && opc_ff != `EEP_OPC_READ && !has_dat) ||
          (st_ff == eep_pkg::ST_DAT && cnt_ff == dlast))
      begin
        done_ff <= 1'b1;
      end
    end
  end

  // Read path; dual-clock array, read side never writes
  always_ff @(posedge sclk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      rd_on_ff <= 1'b0;
      rd_bit_ff <= 1'b0;
      sr_ff <= 16'h0000;
      radr_ff <= 9'h000;
    end
    else if (adr_end && opc_ff == `EEP_OPC_READ)
    begin
      rd_on_ff <= 1'b1;
      rd_bit_ff <= 1'b0;
      sr_ff <= rd_word(nadr, x16_ff);
      radr_ff <= nadr;
    end
    else if (st_ff == eep_pkg::ST_RD)
    begin
      rd_bit_ff <= sr_ff[15];
      sr_ff <= {sr_ff[14:0], 1'b0};
      if (cnt_ff == dlast)
      begin
        radr_ff <= radr_ff + 9'h001;
        sr_ff <= rd_word(radr_ff + 9'h001, x16_ff);
      end
    end
  end

  // Core side
  logic cs_s1_ff, cs_s2_ff, cs_q_ff;
  logic dn_s1_ff, dn_s2_ff, dn_q_ff;
  logic sb_s1_ff, sb_s2_ff, ro_s1_ff, ro_s2_ff, rb_s1_ff, rb_s2_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {cs_s1_ff, cs_s2_ff, cs_q_ff} <= 3'h0;
      {dn_s1_ff, dn_s2_ff, dn_q_ff} <= 3'h0;
      {sb_s1_ff, sb_s2_ff} <= 2'h0;
      {ro_s1_ff, ro_s2_ff, rb_s1_ff, rb_s2_ff} <= 4'h0;
    end
    else
    begin
      {cs_s2_ff, cs_s1_ff} <= {cs_s1_ff, chip_sel};
      cs_q_ff <= cs_s2_ff;
      {dn_s2_ff, dn_s1_ff} <= {dn_s1_ff, done_ff};
      dn_q_ff <= dn_s2_ff;
      {sb_s2_ff, sb_s1_ff} <= {sb_s1_ff, start_ff};
      {ro_s2_ff, ro_s1_ff} <= {ro_s1_ff, rd_on_ff};
      {rb_s2_ff, rb_s1_ff} <= {rb_s1_ff, rd_bit_ff};
    end
  end

  wire dn_rise = dn_s2_ff && !dn_q_ff;
  wire cs_rise = cs_s2_ff && !cs_q_ff;
  wire cs_fall = !cs_s2_ff && cs_q_ff;
  eep_pkg::eep_kind_t nkind, kind_ff;
  assign nkind = dec_kind(opc_ff, adr_ff, x16_ff);
  wire nprog = (nkind == eep_pkg::K_ERASE) ||
    (nkind == eep_pkg::K_WRITE) || (nkind == eep_pkg::K_ERASE_WHOLE_ARRAY) ||
    (nkind == eep_pkg::K_WRITE_WHOLE_ARRAY);

  logic program_enable_cmd_ff, pend_ff, busy_ff, cx16_ff;
  logic [8:0] cadr_ff;
  logic [15:0] cdat_ff;
  logic [31:0] tmr_ff;
  logic [9:0] idx_ff;
  wire take = dn_rise && !busy_ff && !pend_ff;
  wire go = pend_ff && (HV_START || !cs_s2_ff);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      program_enable_cmd_ff <= 1'b0;
    end
    else if (take && nkind == eep_pkg::K_EN)
    begin
      program_enable_cmd_ff <= 1'b1;
    end
    else if (take && nkind == eep_pkg::K_DIS)
    begin
      program_enable_cmd_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_ff <= 1'b0;
      kind_ff <= eep_pkg::K_READ;
      cadr_ff <= 9'h000;
      cdat_ff <= 16'h0000;
      cx16_ff <= 1'b0;
    end
    else if (take && nprog && program_enable_cmd_ff)
    begin
      pend_ff <= 1'b1;
      kind_ff <= nkind;
      cadr_ff <= adr_ff;
      cdat_ff <= dat_ff;
      cx16_ff <= x16_ff;
    end
    else if (go)
    begin
      pend_ff <= 1'b0;
    end
  end

  // Self-timed cycle runs on the core clock alone
  wire all_op = (kind_ff == eep_pkg::K_ERASE_WHOLE_ARRAY) ||
    (kind_ff == eep_pkg::K_WRITE_WHOLE_ARRAY);
  wire [9:0] lim = all_op ? 10'(`EEP_BYTES) :
    (cx16_ff ? 10'h002 : 10'h001);
  wire wr_now = busy_ff && (idx_ff < lim);
  wire [8:0] wa = all_op ? idx_ff[8:0] :
    (cx16_ff ? {cadr_ff[7:0], idx_ff[0]} : cadr_ff);
  wire erase_op = (kind_ff == eep_pkg::K_ERASE) ||
    (kind_ff == eep_pkg::K_ERASE_WHOLE_ARRAY);
  wire [7:0] wb = erase_op ? `EEP_ERASED :
    ((cx16_ff && wa[0]) ? cdat_ff[15:8] : cdat_ff[7:0]);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_ff <= 1'b0;
      tmr_ff <= 32'h0000_0000;
      idx_ff <= 10'h000;
    end
    else if (go)
    begin
      busy_ff <= 1'b1;
      tmr_ff <= PROG_LAST;
      idx_ff <= 10'h000;
    end
    else if (busy_ff)
    begin
      tmr_ff <= tmr_ff - 32'h0000_0001;
      busy_ff <= (tmr_ff != 32'h0000_0000);
      if (wr_now)
      begin
        idx_ff <= idx_ff + 10'h001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (wr_now)
    begin
      mem[wa] <= wb;
    end
  end

  // Status visibility
  logic [6:0] low_ff;
  logic arm_ff, stat_ff, sbc_ff;
  wire clr = cs_fall && sbc_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_ff <= 7'h00;
      sbc_ff <= 1'b0;
    end
    else
    begin
      if (cs_s2_ff)
      begin
        low_ff <= 7'h00;
      end
      else if (low_ff != CSL_CYC)
      begin
        low_ff <= low_ff + 7'h01;
      end
      if (cs_fall)
      begin
        sbc_ff <= 1'b0;
      end
      else if (sb_s2_ff)
      begin
        sbc_ff <= 1'b1;
      end
    end
  end

  // A new cycle arming wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arm_ff <= 1'b0;
      stat_ff <= 1'b0;
    end
    else
    begin
      if (clr)
      begin
        arm_ff <= 1'b0;
        stat_ff <= 1'b0;
      end
      if (go)
      begin
        arm_ff <= 1'b1;
      end
      if (cs_rise && low_ff == CSL_CYC && arm_ff)
      begin
        stat_ff <= 1'b1;
      end
    end
  end

  logic so_ff, soe_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      so_ff <= 1'b0;
      soe_ff <= 1'b0;
    end
    else
    begin
      soe_ff <= cs_s2_ff && (ro_s2_ff || stat_ff);
      so_ff <= ro_s2_ff ? rb_s2_ff : !busy_ff;
    end
  end

  assign serial_out = so_ff;
  assign serial_out_oe = soe_ff;
  assign prog_busy = busy_ff;
  assign prog_enabled = program_enable_cmd_ff;

  erase_fill_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_now && erase_op) |-> (wb == `EEP_ERASED))
    else $error("erase writes a byte other than all ones");

  prog_start_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(busy_ff) |-> $past(pend_ff) && (HV_START || !$past(cs_s2_ff)))
    else $error("cycle started without pending op or select low");

  status_show_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (stat_ff && cs_s2_ff && !ro_s2_ff) |=>
      (soe_ff && so_ff == !$past(busy_ff)))
    else $error("status not driven as inverted busy");

  status_clear_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (clr && !go) |=> !stat_ff && !arm_ff)
    else $error("start bit and deselect did not clear status");

  busy_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(busy_ff) |-> busy_ff[*8])
    else $error("programming cycle ended too early");

  disabled_block_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && nprog && !program_enable_cmd_ff) |=> !pend_ff)
    else $error("programming taken while disabled");

  all_walk_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($rose(busy_ff) && all_op) |-> ##[1:600] (idx_ff == 10'h200))
    else $error("whole array not walked");

  float_low_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !cs_s2_ff |=> !soe_ff)
    else $error("output driven while deselected");

  read_drive_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ro_s2_ff && cs_s2_ff) |=> soe_ff && (so_ff == $past(rb_s2_ff)))
    else $error("read bit not driven");

  dummy_zero_a: assert property (
    @(posedge sclk) disable iff (!lrst_n)
    (adr_end && opc_ff == `EEP_OPC_READ) |=> rd_on_ff && !rd_bit_ff)
    else $error("read lacks leading zero");

  idle_hold_a: assert property (
    @(posedge sclk) disable iff (!lrst_n)
    (st_ff == eep_pkg::ST_IDLE && !serial_in) |=>
      (st_ff == eep_pkg::ST_IDLE && !start_ff))
    else $error("state moved without start bit");

endmodule

// ===== tb/eep_host.sv
/*
  Host model: drives select, serial clock and data in; sees data out.
  Assumes the bench calls one task at a time, never two at once.
*/
`timescale 1ns/1ns
module eep_host (
  input wire logic clk,
  input wire logic serial_out,
  output logic sclk,
  output logic chip_sel,
  output logic serial_in
);
  logic [31:0] rx;

  initial
  begin
    sclk = 1'b0;
    chip_sel = 1'b0;
    serial_in = 1'b0;
    rx = 32'h0;
  end

  // Sample just before the next rise: data out lags by core clocks
  task automatic sbit(input logic b);
    serial_in = b;
    #16;
    rx = {rx[30:0], serial_out};
    sclk = 1'b1;
    #16;
    sclk = 1'b0;
  endtask

  task automatic raise();
    @(negedge clk);
    chip_sel = 1'b1;
  endtask

  // Two idle clocks also let the size pin synchroniser settle
  task automatic open_frame();
    raise();
    #3;
    sbit(1'b0);
    sbit(1'b0);
  endtask

  task automatic close_frame();
    #16;
    rx = {rx[30:0], serial_out};
    @(negedge clk);
    chip_sel = 1'b0;
    serial_in = ~serial_in;
    repeat (80) @(negedge clk);
  endtask

  task automatic xfer(input logic [1:0] op, input logic [8:0] a,
                      input logic [15:0] d, input int nx, input bit x16);
    open_frame();
    sbit(1'b1);
    sbit(op[1]);
    sbit(op[0]);
    for (int i = (x16 ? 7 : 8); i >= 0; i--) sbit(a[i]);
    for (int i = nx - 1; i >= 0; i--) sbit(d[i]);
    close_frame();
  endtask
endmodule

// ===== tb/tb_top.sv
/*
  Self-checking bench of the command engine: programming, reads,
  status and select handling, all through the host model.
  Assumes the engine, its constants and the host model are compiled.
*/
`timescale 1ns/1ns
`include "eep_consts.svh"
module tb_top;
  localparam int PCYC = 600;
  logic clk;
  logic rst_n;
  logic sclk;
  logic chip_sel;
  logic serial_in;
  logic word_size_select;
  logic serial_out;
  logic serial_out_oe;
  logic prog_busy;
  logic prog_enabled;
  int error_cnt;
  int n_checks;
  int cyc;
  // Released line shows the inverse of serial_out: no pull-up
  wire do_line = serial_out_oe ? serial_out : ~serial_out;

  eep_cmd_engine #(.PROG_CYC(PCYC), .HV_START(1'b0),
    .ORG_MODE(`EEP_ORG_PIN)) uut (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .chip_sel(chip_sel),
    .serial_in(serial_in),
    .word_size_select(word_size_select),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .prog_busy(prog_busy),
    .prog_enabled(prog_enabled)
  );

  eep_host host (
    .clk(clk),
    .serial_out(do_line),
    .sclk(sclk),
    .chip_sel(chip_sel),
    .serial_in(serial_in)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Run is about 9700 cycles; the ceiling leaves ample margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      $display("wrong value at %0t: timeout", $time);
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h",
               $time, what, got, exp);
    end
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (prog_busy !== 1'b0 && k < PCYC + 100)
    begin
      @(negedge clk);
      k++;
    end
    check(prog_busy, 0, "cycle end");
  endtask

  task automatic rd(input logic [8:0] a, input int nx, input bit x16,
                    input logic [31:0] exp);
    host.xfer(`EEP_OPC_READ, a, 16'h0000, nx, x16);
    check(host.rx & ((32'h1 << (nx + 1)) - 32'h1), exp, "read");
  endtask

  task automatic status_poll();
    host.raise();
    repeat (8) @(negedge clk);
    check({serial_out_oe, serial_out}, 2'h2, "busy shown");
    wait_ready();
    repeat (8) @(negedge clk);
    check({serial_out_oe, serial_out}, 2'h3, "ready shown");
    host.sbit(1'b1);
    host.close_frame();
    check(serial_out_oe, 0, "released");
    host.raise();
    repeat (8) @(negedge clk);
    check(serial_out_oe, 0, "status cleared");
    host.close_frame();
  endtask

  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    word_size_select = 1'b0;
    fork
      host.sbit(1'b0);
    join_none
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    check({prog_enabled, serial_out_oe}, 0, "power-up");
    host.xfer(`EEP_OPC_WRITE, 9'h005, 16'h00A5, 8, 0);
    check(prog_busy, 0, "locked write");
    host.xfer(`EEP_OPC_EXT, {`EEP_EXT_EN, 7'h00}, 16'h0, 0, 0);
    check(prog_enabled, 1, "enable");
    host.xfer(`EEP_OPC_WRITE, 9'h1FF, 16'h003C, 8, 0);
    check(prog_busy, 1, "write start");
    status_poll();
    host.xfer(`EEP_OPC_ERASE, 9'h000, 16'h0, 0, 0);
    check(prog_busy, 1, "erase start");
    check(serial_out_oe, 0, "quiet while low");
    wait_ready();
    host.raise();
    repeat (8) @(negedge clk);
    check({serial_out_oe, serial_out}, 2'h3, "late status");
    host.close_frame();
    rd(9'h1FF, 16, 0, {1'b0, 8'h3C, 8'hFF});
    host.xfer(`EEP_OPC_EXT, {`EEP_EXT_DIS, 7'h00}, 16'h0, 0, 0);
    check(prog_enabled, 0, "disable");
    rd(9'h1FF, 16, 0, {1'b0, 8'h3C, 8'hFF});
    host.xfer(`EEP_OPC_ERASE, 9'h1FF, 16'h0, 0, 0);
    check(prog_busy, 0, "locked erase");
    host.xfer(`EEP_OPC_WRITE, 9'h1FF, 16'h0011, 8, 0);
    check(prog_busy, 0, "locked write");
    host.xfer(`EEP_OPC_EXT, {`EEP_EXT_ERASE_WHOLE_ARRAY, 7'h00}, 16'h0, 0, 0);
    check(prog_busy, 0, "locked erase-all");
    host.xfer(`EEP_OPC_EXT, {`EEP_EXT_WRITE_WHOLE_ARRAY, 7'h00}, 16'h0022, 8, 0);
    check(prog_busy, 0, "locked write-all");
    rd(9'h1FF, 8, 0, {1'b0, 8'h3C});
    host.xfer(`EEP_OPC_EXT, {`EEP_EXT_EN, 7'h00}, 16'h0, 0, 0);
    // Four surplus bits after the word must be ignored
    host.xfer(`EEP_OPC_WRITE, 9'h010, 16'h0C3F, 12, 0);
    wait_ready();
    rd(9'h010, 8, 0, {1'b0, 8'hC3});
    @(negedge clk);
    word_size_select = 1'b1;
    host.xfer(`EEP_OPC_WRITE, 9'h080, 16'h1234, 16, 1);
    wait_ready();
    rd(9'h080, 16, 1, {1'b0, 16'h1234});
    @(negedge clk);
    word_size_select = 1'b0;
    rd(9'h100, 16, 0, {1'b0, 8'h34, 8'h12});
    host.xfer(`EEP_OPC_EXT, {`EEP_EXT_WRITE_WHOLE_ARRAY, 7'h00}, 16'h005A, 8, 0);
    check(prog_busy, 1, "write-all start");
    wait_ready();
    rd(9'h1FF, 16, 0, {1'b0, 8'h5A, 8'h5A});
    host.xfer(`EEP_OPC_EXT, {`EEP_EXT_ERASE_WHOLE_ARRAY, 7'h00}, 16'h0, 0, 0);
    check(prog_busy, 1, "erase-all start");
    wait_ready();
    rd(9'h007, 16, 0, {1'b0, 8'hFF, 8'hFF});
    // Power cycle: enable is lost, array contents are kept
    @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    check({prog_enabled, prog_busy, serial_out_oe}, 0, "re-power");
    rd(9'h007, 8, 0, {1'b0, 8'hFF});
    host.xfer(`EEP_OPC_EXT, {`EEP_EXT_DIS, 7'h00}, 16'h0, 0, 0);
    check(prog_enabled, 0, "final disable");
    stop_test();
  end
endmodule
